// ===== rtl/ess_pkg.sv
package ess_pkg;
  // register indices on the plain register port
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_RESP      = 4'h1;
  localparam logic [3:0] REG_TIMEOUT   = 4'h2;
  localparam logic [3:0] REG_EXTRA     = 4'h3;
  localparam logic [3:0] REG_B2T       = 4'h4;
  localparam logic [3:0] REG_TTZ       = 4'h5;
  localparam logic [3:0] REG_ZERO      = 4'h6;
  localparam logic [3:0] REG_ENC_ZERO  = 4'h7;
  localparam logic [3:0] REG_RAMP_UP   = 4'h8;
  localparam logic [3:0] REG_RAMP_LO   = 4'h9;
  localparam logic [3:0] REG_STATUS    = 4'ha;
  localparam logic [3:0] REG_IRQ_STAT  = 4'hb;
  localparam logic [3:0] REG_IRQ_MASK  = 4'hc;
  // control field positions
  localparam int CTRL_RAMP_BIT  = 0;
  localparam int CTRL_BRAKE_BIT = 1;
  // event bit positions
  localparam int EV_REQ  = 0;
  localparam int EV_TQ   = 1;
  localparam int EV_DONE = 2;
  localparam int EV_TOUT = 3;
  localparam int EV_RAMP = 4;
  localparam int EV_W    = 5;
  // reset values
  localparam logic [15:0] CFG_RST   = 16'h0000;
  localparam logic [15:0] LIMIT_RST = 16'hffff;
  // delays count in 1 ms ticks
  localparam int CLK_MHZ    = 40;
  localparam int TICK_US    = 1000;
  localparam int TICK_CYC   = CLK_MHZ * TICK_US;

  typedef struct packed {
    logic        ramp_mode;
    logic        brake_en;
    logic [15:0] resp;
    logic [15:0] timeout;
    logic [15:0] extra;
    logic [15:0] b2t;
    logic [15:0] ttz;
    logic [15:0] zero;
    logic [15:0] enc_zero;
    logic [15:0] ramp_up;
    logic [15:0] ramp_lo;
  } ess_cfg_type;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_RESP  = 7'h02,
    ST_MON   = 7'h04,
    ST_EXTRA = 7'h08,
    ST_LEAD  = 7'h10,
    ST_STOP  = 7'h20,
    ST_DONE  = 7'h40
  } ess_state_type;
endpackage

// ===== rtl/ess_stop_seq.sv
// Overview of operation
// - time variant: request starts timeout counter, raises stop-active
// - time variant: zero speed applies torque-off, torque-off and done flags
// - ack accepted only when done is set and request withdrawn
// - brake configured: brake activates whenever torque-off is applied
// - negative brake delay: brake first, torque-off after delay magnitude
// - zero or positive brake delay: brake and torque-off together
// - optional extra delay before torque-off once zero speed reached
// - time variant: timeout expiry forces torque-off regardless of speed
// - valid ack releases torque-off and clears all indications
// - ramp variant: request raises stop-active, no timeout counter
// - ramp variant: after response time supervise ramp limits
// - speed outside a ramp limit applies torque-off without the extra delay
// - ramp variant: zero speed ends supervision, applies torque-off
// - ramp variant with brake: done only after brake time-to-zero
// - after ack in ramp variant drive may modulate again
// - time variant uses encoder zero limit, ramp variant general one
`timescale 1ns/1ps
`default_nettype none
module ess_stop_seq
  import ess_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_stop_req,
  input  wire logic        i_ack,
  input  wire logic [15:0] i_speed,
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [15:0]      o_rdata,
  output logic             o_torque_off,
  output logic             o_brake,
  output logic             o_stop_active,
  output logic             o_stop_done,
  output logic             o_torque_off_flag,
  output logic             o_ramp_sup,
  output logic             o_irq
);
  ess_cfg_type   cfg_ff;
  ess_state_type st_ff;
  logic [1:0]  req_sync_ff, ack_sync_ff;
  logic        ack_prev_ff;
  logic [31:0] tick_cnt_ff;
  logic        tick_ff;
  logic [15:0] cnt_ff, to_cnt_ff;
  logic        to_run_ff;
  logic [EV_W-1:0] irq_st_ff, irq_mask_ff;
  logic [15:0] rdata_ff;
  logic        tq_ff, brk_ff, act_ff, done_ff, sup_ff, irq_ff;

  // synchronised pins; only the second stage, index 1, is read by logic
  wire req_s    = req_sync_ff[1];
  wire ack_rise = ack_sync_ff[1] & ~ack_prev_ff;

  // speed comparisons
  wire [15:0] zlim = cfg_ff.ramp_mode ? cfg_ff.zero : cfg_ff.enc_zero;
  wire at_zero  = i_speed <= zlim;
  wire ramp_bad = cfg_ff.ramp_mode &&
                  (i_speed > cfg_ff.ramp_up || i_speed < cfg_ff.ramp_lo);
  wire to_hit   = to_run_ff && (to_cnt_ff >= cfg_ff.timeout);
  wire [15:0] b2t_mag = cfg_ff.b2t[15] ? 16'(-cfg_ff.b2t) : cfg_ff.b2t;
  wire brake_lead = cfg_ff.brake_en && cfg_ff.b2t[15];
  wire in_resp  = st_ff == ST_RESP;
  wire in_mon   = st_ff == ST_MON;
  wire pre_stop = in_resp || in_mon || st_ff == ST_EXTRA;

  // decisions made in the response, monitoring, extra, brake lead, stop and done phases
  wire force_to   = pre_stop && to_hit;
  wire force_ramp = in_mon && !at_zero && ramp_bad;
  wire zero_hit   = in_mon && at_zero;
  wire extra_ok   = st_ff == ST_EXTRA && cnt_ff >= cfg_ff.extra;
  wire apply_now  = force_to || force_ramp || extra_ok;
  wire lead_ok    = st_ff == ST_LEAD && cnt_ff >= b2t_mag;
  wire ttz_ok     = !(cfg_ff.ramp_mode && cfg_ff.brake_en) ||
                    cnt_ff >= cfg_ff.ttz;
  wire done_now   = st_ff == ST_STOP && at_zero && ttz_ok;
  wire ack_ok     = st_ff == ST_DONE && done_ff && !req_s && ack_rise;

  // events feeding the sticky status
  wire [EV_W-1:0] ev;
  assign ev[EV_REQ]  = st_ff == ST_IDLE && req_s;
  assign ev[EV_TQ]   = (apply_now && !brake_lead) || lead_ok;
  assign ev[EV_DONE] = done_now;
  assign ev[EV_TOUT] = force_to;
  assign ev[EV_RAMP] = force_ramp;

  // register read selection
  wire [15:0] status_w = {9'h000, sup_ff, done_ff, act_ff, brk_ff, tq_ff,
                          cfg_ff.brake_en, cfg_ff.ramp_mode};
  wire [15:0] rd_mux =
    i_addr == REG_CTRL     ? {14'h0000, cfg_ff.brake_en, cfg_ff.ramp_mode} :
    i_addr == REG_RESP     ? cfg_ff.resp :
    i_addr == REG_TIMEOUT  ? cfg_ff.timeout :
    i_addr == REG_EXTRA    ? cfg_ff.extra :
    i_addr == REG_B2T      ? cfg_ff.b2t :
    i_addr == REG_TTZ      ? cfg_ff.ttz :
    i_addr == REG_ZERO     ? cfg_ff.zero :
    i_addr == REG_ENC_ZERO ? cfg_ff.enc_zero :
    i_addr == REG_RAMP_UP  ? cfg_ff.ramp_up :
    i_addr == REG_RAMP_LO  ? cfg_ff.ramp_lo :
    i_addr == REG_STATUS   ? status_w :
    i_addr == REG_IRQ_STAT ? {11'h000, irq_st_ff} :
    i_addr == REG_IRQ_MASK ? {11'h000, irq_mask_ff} : 16'h0000;
  wire irq_clr = i_rd && i_addr == REG_IRQ_STAT;

  // two-flop synchronisers for the request and ack pins
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_sync_ff <= 2'h0;
      ack_sync_ff <= 2'h0;
      ack_prev_ff <= 1'h0;
    end else begin
      req_sync_ff <= {req_sync_ff[0], i_stop_req};
      ack_sync_ff <= {ack_sync_ff[0], i_ack};
      ack_prev_ff <= ack_sync_ff[1];
    end
  end

  // millisecond tick; delays are coarse but need only 16-bit counters
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt_ff <= 32'h0;
      tick_ff     <= 1'h0;
    end else begin
      tick_ff     <= tick_cnt_ff == 32'(TICK_CYCLES - 1);
      tick_cnt_ff <= (tick_cnt_ff == 32'(TICK_CYCLES - 1)) ? 32'h0
                                                           : tick_cnt_ff + 32'h1;
    end
  end

  // configuration writes; a stop in progress sees changes at once
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_ff          <= '0;
      cfg_ff.ramp_up  <= LIMIT_RST;
      cfg_ff.ramp_lo  <= CFG_RST;
      irq_mask_ff     <= '0;
    end else if (i_wr) begin
      case (i_addr)
        REG_CTRL: begin
          cfg_ff.ramp_mode <= i_wdata[CTRL_RAMP_BIT];
          cfg_ff.brake_en  <= i_wdata[CTRL_BRAKE_BIT];
        end
        REG_RESP:     cfg_ff.resp     <= i_wdata;
        REG_TIMEOUT:  cfg_ff.timeout  <= i_wdata;
        REG_EXTRA:    cfg_ff.extra    <= i_wdata;
        REG_B2T:      cfg_ff.b2t      <= i_wdata;
        REG_TTZ:      cfg_ff.ttz      <= i_wdata;
        REG_ZERO:     cfg_ff.zero     <= i_wdata;
        REG_ENC_ZERO: cfg_ff.enc_zero <= i_wdata;
        REG_RAMP_UP:  cfg_ff.ramp_up  <= i_wdata;
        REG_RAMP_LO:  cfg_ff.ramp_lo  <= i_wdata;
        REG_IRQ_MASK: irq_mask_ff     <= i_wdata[EV_W-1:0];
        default: ;
      endcase
    end
  end

  // read data one cycle later; sticky status, a new event beats the clear
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_ff  <= 16'h0000;
      irq_st_ff <= '0;
      irq_ff    <= 1'h0;
    end else begin
      rdata_ff  <= i_rd ? rd_mux : 16'h0000;
      irq_st_ff <= (irq_clr ? '0 : irq_st_ff) | ev;
      irq_ff    <= |(((irq_clr ? '0 : irq_st_ff) | ev) & irq_mask_ff);
    end
  end

  // stop timeout counter, time variant only
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      to_run_ff <= 1'h0;
      to_cnt_ff <= 16'h0000;
    end else if (ev[EV_REQ]) begin
      to_run_ff <= !cfg_ff.ramp_mode;
      to_cnt_ff <= 16'h0000;
    end else if (!pre_stop) begin
      to_run_ff <= 1'h0;
    end else if (tick_ff && to_run_ff && !to_hit) begin
      to_cnt_ff <= to_cnt_ff + 16'h1;
    end
  end

  // stop sequencer; outputs other than ramp supervision latch until a valid ack
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff   <= ST_IDLE;
      cnt_ff  <= 16'h0000;
      tq_ff   <= 1'h0;
      brk_ff  <= 1'h0;
      act_ff  <= 1'h0;
      done_ff <= 1'h0;
      sup_ff  <= 1'h0;
    end else begin
      if (tick_ff && cnt_ff != 16'hffff)
        cnt_ff <= cnt_ff + 16'h1;
      // phase walk; the ifs below override the case on purpose
      case (st_ff)
        ST_IDLE: if (req_s) begin
          act_ff <= 1'h1;
          cnt_ff <= 16'h0000;
          st_ff  <= ST_RESP;
        end
        ST_RESP: if (force_to) begin
          st_ff <= ST_EXTRA;
        end else if (cnt_ff >= cfg_ff.resp) begin
          sup_ff <= cfg_ff.ramp_mode;
          st_ff  <= ST_MON;
        end
        ST_MON: if (force_to || force_ramp) begin
          sup_ff <= 1'h0;
          st_ff  <= ST_EXTRA;
        end else if (zero_hit) begin
          sup_ff <= 1'h0;
          cnt_ff <= 16'h0000;
          st_ff  <= ST_EXTRA;
        end
        default: ;
      endcase
      // forced stops skip the extra delay
      if (apply_now) begin
        cnt_ff <= 16'h0000;
        if (brake_lead) begin
          brk_ff <= 1'h1;
          st_ff  <= ST_LEAD;
        end else begin
          tq_ff  <= 1'h1;
          brk_ff <= cfg_ff.brake_en;
          st_ff  <= ST_STOP;
        end
      end
      // cnt keeps running from brake activation into the stop phase
      if (lead_ok) begin
        tq_ff <= 1'h1;
        st_ff <= ST_STOP;
      end
      // done waits for zero speed and, ramp with brake, the settle time
      if (done_now) begin
        done_ff <= 1'h1;
        st_ff   <= ST_DONE;
      end
      // only a valid ack clears the latches; speed changes are ignored
      if (ack_ok) begin
        tq_ff   <= 1'h0;
        brk_ff  <= 1'h0;
        act_ff  <= 1'h0;
        done_ff <= 1'h0;
        st_ff   <= ST_IDLE;
      end
    end
  end

  assign o_rdata           = rdata_ff;
  assign o_torque_off      = tq_ff;
  assign o_brake           = brk_ff;
  assign o_stop_active     = act_ff;
  assign o_stop_done       = done_ff;
  assign o_torque_off_flag = tq_ff;
  assign o_ramp_sup        = sup_ff;
  assign o_irq             = irq_ff;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  a_req_sets_active: assert property (
    st_ff == ST_IDLE && req_s |=> act_ff && st_ff == ST_RESP)
    else $error("request did not raise stop active");
  a_ramp_no_timer: assert property (
    ev[EV_REQ] && cfg_ff.ramp_mode |=> !to_run_ff)
    else $error("timeout runs in ramp variant");
  a_zero_torque: assert property (
    extra_ok && !brake_lead |=> tq_ff && st_ff == ST_STOP)
    else $error("torque off missing after zero speed");
  a_ack_needs_done: assert property (
    $fell(act_ff) |-> $past(done_ff) && !$past(req_s))
    else $error("release without done or with request");
  a_brake_with_tq: assert property (
    $rose(tq_ff) && cfg_ff.brake_en |-> brk_ff)
    else $error("brake not active with torque off");
  a_brake_lead: assert property (
    apply_now && brake_lead |=> brk_ff && !tq_ff && st_ff == ST_LEAD)
    else $error("brake did not lead torque off");
  a_timeout_force: assert property (
    force_to && !brake_lead |=> tq_ff)
    else $error("timeout did not force torque off");
  a_ack_release: assert property (
    ack_ok |=> !tq_ff && !brk_ff && !act_ff && !done_ff && st_ff == ST_IDLE)
    else $error("ack did not release outputs");
  a_ramp_fault: assert property (
    force_ramp && !brake_lead |=> tq_ff && !sup_ff)
    else $error("ramp fault did not apply torque off");
  a_ttz_hold: assert property (
    $rose(done_ff) && cfg_ff.ramp_mode && cfg_ff.brake_en
      |-> $past(cnt_ff) >= cfg_ff.ttz)
    else $error("done before brake time to zero");
  a_latched: assert property (
    tq_ff && !ack_ok |=> tq_ff)
    else $error("torque off dropped without ack");

  // latched outputs and indications, held until a valid ack
  a_active_held: assert property (
    act_ff && !ack_ok |=> act_ff)
    else $error("stop active dropped without ack");
  a_done_held: assert property (
    done_ff && !ack_ok |=> done_ff)
    else $error("stop done dropped without ack");
  a_brake_held: assert property (
    brk_ff && !ack_ok |=> brk_ff)
    else $error("brake dropped without ack");
  a_tq_needs_act: assert property (
    tq_ff |-> act_ff)
    else $error("torque off without stop active");
  a_idle_quiet: assert property (
    st_ff == ST_IDLE |-> !tq_ff && !brk_ff && !done_ff && !act_ff)
    else $error("outputs active while idle");
  a_tq_in_stop: assert property (
    tq_ff |-> st_ff == ST_STOP || st_ff == ST_DONE)
    else $error("torque off outside stop phases");

  // torque-off timing against brake and delays
  a_same_time: assert property (
    apply_now && cfg_ff.brake_en && !brake_lead |=> tq_ff && brk_ff)
    else $error("brake and torque off not together");
  a_extra_wait: assert property (
    st_ff == ST_EXTRA && !apply_now |=> !tq_ff)
    else $error("torque off before extra delay");
  a_lead_wait: assert property (
    st_ff == ST_LEAD && !lead_ok |=> !tq_ff && brk_ff)
    else $error("torque off before brake lead elapsed");
  a_lead_cause: assert property (
    $rose(brk_ff) && !tq_ff |-> $past(brake_lead))
    else $error("brake alone without negative delay");
  a_done_with_tq: assert property (
    $rose(done_ff) |-> tq_ff && act_ff)
    else $error("done without torque off");

  // supervision, timeout counter and read port
  a_sup_in_mon: assert property (
    sup_ff |-> st_ff == ST_MON)
    else $error("supervision outside monitoring");
  a_sup_rise: assert property (
    $rose(sup_ff) |-> $past(in_resp))
    else $error("supervision started off response end");
  a_zero_ends_sup: assert property (
    zero_hit |=> !sup_ff && st_ff != ST_MON)
    else $error("supervision kept after zero speed");
  a_ramp_needs_sup: assert property (
    force_ramp |-> sup_ff)
    else $error("ramp fault without supervision");
  a_timer_start: assert property (
    ev[EV_REQ] && !cfg_ff.ramp_mode |=> to_run_ff && to_cnt_ff == 16'h0000)
    else $error("timeout counter not started");
  a_rdata_idle:
    assert property (!i_rd |=> rdata_ff == 16'h0000)
    else $error("read data not zero without read");

  // main scenarios reached
  c_brake_lead: cover property (lead_ok);
  c_zero_stop: cover property (zero_hit ##[1:300] done_now);
  c_timeout: cover property (force_to);
  c_ramp_fault: cover property (force_ramp);
  c_full_cycle: cover property (ack_ok);
endmodule
`default_nettype wire

// ===== tb/ess_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
// drive side: holds speed, ramps it down a fixed step per cycle after a lag
module ess_drive_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_stop_active,
  input  wire logic        i_load,
  input  wire logic [15:0] i_load_val,
  input  wire logic [3:0]  i_rate,
  input  wire logic [7:0]  i_lag,
  output logic      [15:0] o_speed
);
  logic [7:0] lag_ff;
  // rate 0 models a drive that fails to decelerate at all
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lag_ff  <= 8'h00;
      o_speed <= 16'h0000;
    end else if (i_load) begin
      lag_ff  <= 8'h00;
      o_speed <= i_load_val;
    end else if (!i_stop_active) begin
      lag_ff <= 8'h00;
    end else if (lag_ff < i_lag) begin
      lag_ff <= lag_ff + 8'h01;
    end else begin
      o_speed <= (o_speed > {12'h000, i_rate}) ? o_speed - {12'h000, i_rate} : 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top
  import ess_pkg::*;
;
  localparam int TK = 4;
  logic        clk, rst_n, stop_req, ack, wr, rd, ld, rd_pend;
  logic        tq, br, act, done, tqf, sup, irq;
  logic        tq_d, br_d, dn_d, sup_d, crossed, sup_seen;
  logic [3:0]  addr, rate;
  logic [7:0]  lag;
  logic [15:0] wdata, ld_val, speed, rdata, zlim, sp_tq, sp_br, exp_v;
  logic [15:0] exp_q [$];
  int          cyc, t_tq, t_br, t_dn, t_sup, t_cross, err_total, n_checks;

  ess_stop_seq #(.TICK_CYCLES(TK)) dut (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_stop_req(stop_req), .i_ack(ack),
    .i_speed(speed), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_torque_off(tq), .o_brake(br), .o_stop_active(act),
    .o_stop_done(done), .o_torque_off_flag(tqf), .o_ramp_sup(sup), .o_irq(irq));
  ess_drive_model drv (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_stop_active(act), .i_load(ld),
    .i_load_val(ld_val), .i_rate(rate), .i_lag(lag), .o_speed(speed));

  // 40 MHz core clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // rise times of outputs, so ordering and delays can be judged later
  always @(posedge clk) begin
    cyc++;
    rd_pend <= rd;
    if (tq && !tq_d) begin t_tq = cyc; sp_tq = speed; end
    if (br && !br_d) begin t_br = cyc; sp_br = speed; end
    if (done && !dn_d) t_dn = cyc;
    if (sup && !sup_d) t_sup = cyc;
    if (sup) sup_seen = 1'b1;
    if (!crossed && speed <= zlim) begin crossed = 1'b1; t_cross = cyc; end
    {tq_d, br_d, dn_d, sup_d} = {tq, br, done, sup};
  end

  // read answers stand one cycle only, so match them mid-cycle
  always @(negedge clk) if (rd_pend) begin
    exp_v = exp_q.pop_front();
    `CHK("rdata", exp_v, rdata)
  end

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
  endtask

  task automatic start_stop(input logic [15:0] sp, input logic [3:0] r, input logic [15:0] z);
    @(posedge clk);
    ld <= 1'b1;
    ld_val <= sp;
    rate <= r;
    zlim <= z;
    @(posedge clk);
    ld <= 1'b0;
    stop_req <= 1'b1;
    @(negedge clk);
    crossed = 1'b0;
    sup_seen = 1'b0;
  endtask

  // bounded wait; a hang here shows up as failed checks afterwards
  task automatic wait_done();
    repeat (3000) if (done !== 1'b1) @(posedge clk);
    @(negedge clk);
    `CHK("done reached", 1'b1, done)
  endtask

  // speed jumps up and ack comes while request still held: nothing may move
  task automatic hold_check(input logic [15:0] e);
    @(posedge clk);
    ld <= 1'b1;
    ld_val <= 16'h0800;
    ack <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
    repeat (4) @(posedge clk);
    ack <= 1'b0;
    repeat (4) @(posedge clk);
    rd_reg(REG_STATUS, e);
  endtask

  task automatic release_stop(input logic [15:0] e);
    @(posedge clk);
    stop_req <= 1'b0;
    repeat (4) @(posedge clk);
    ack <= 1'b1;
    repeat (4) @(posedge clk);
    ack <= 1'b0;
    repeat (4) @(posedge clk);
    rd_reg(REG_STATUS, e);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // watchdog: five tests of at most a few thousand cycles each
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end

  initial begin
    {stop_req, ack, wr, rd, ld, rd_pend, tq_d, br_d, dn_d, sup_d, crossed, sup_seen} = '0;
    {addr, rate, wdata, ld_val, zlim} = '0;
    lag = 8'd12;
    {cyc, err_total, n_checks} = '0;
    void'($urandom(54140));
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // reset values, unmapped index, read-only status
    rd_reg(REG_CTRL, CFG_RST);
    rd_reg(REG_RAMP_UP, LIMIT_RST);
    wr_reg(REG_STATUS, 16'h007f);
    rd_reg(REG_STATUS, 16'h0000);
    wr_reg(4'hd, 16'h1234);
    rd_reg(4'hd, 16'h0000);
    $display("test regs done");
    // time variant, extra delay, general limit set wider than encoder limit
    wr_reg(REG_RESP, 16'h0001);
    wr_reg(REG_TIMEOUT, 16'h0fff);
    wr_reg(REG_EXTRA, 16'h0002);
    wr_reg(REG_ZERO, 16'h0064);
    wr_reg(REG_ENC_ZERO, 16'h000a);
    start_stop(16'(500 + $urandom % 500), 4'(1 + $urandom % 4), 16'h000a);
    repeat (20) if (act !== 1'b1) @(posedge clk);
    `CHK("stop active", 1'b1, act)
    `CHK("torque_off early", 1'b0, tq)
    wait_done();
    `CHK("speed at torque_off", 1'b1, sp_tq <= 16'h000a)
    `CHK("extra delay", 1'b1, (t_tq - t_cross) >= 4)
    `CHK("torque_off flag", tq, tqf)
    `CHK("brake unused", 1'b0, br)
    hold_check(16'h0034);
    release_stop(16'h0000);
    `CHK("irq masked", 1'b0, irq)
    rd_reg(REG_IRQ_STAT, 16'h0007);
    $display("test time variant done");
    // drive stalls: the timeout forces torque-off at full speed
    wr_reg(REG_TIMEOUT, 16'h0002);
    wr_reg(REG_IRQ_MASK, 16'h0008);
    start_stop(16'h0400, 4'h0, 16'h000a);
    repeat (200) if (tq !== 1'b1) @(posedge clk);
    `CHK("timeout torque_off", 1'b1, tq)
    rate <= 4'h4;
    wait_done();
    `CHK("speed at timeout", 16'h0400, sp_tq)
    `CHK("irq timeout", 1'b1, irq)
    release_stop(16'h0000);
    rd_reg(REG_IRQ_STAT, 16'h000f);
    repeat (2) @(negedge clk);
    `CHK("irq cleared", 1'b0, irq)
    $display("test timeout done");
    // ramp variant, brake leads torque-off, timeout must be ignored
    wr_reg(REG_CTRL, 16'h0003);
    wr_reg(REG_TIMEOUT, 16'h0001);
    wr_reg(REG_B2T, 16'hfffe);
    wr_reg(REG_TTZ, 16'h0003);
    start_stop(16'(500 + $urandom % 500), 4'(1 + $urandom % 4), 16'h0064);
    wait_done();
    `CHK("speed at brake", 1'b1, sp_br <= 16'h0064 && sp_br > 16'h000a)
    `CHK("brake lead", 1'b1, (t_tq - t_br) >= 4 && (t_tq - t_br) <= 12)
    `CHK("time to zero", 1'b1, (t_dn - t_br) >= 8)
    `CHK("supervision seen", 1'b1, sup_seen)
    `CHK("supervision ended", 1'b0, sup)
    hold_check(16'h003f);
    release_stop(16'h0003);
    $display("test ramp brake done");
    // ramp limit violated at once; brake and torque-off together
    wr_reg(REG_B2T, 16'h0003);
    wr_reg(REG_TTZ, 16'h0001);
    wr_reg(REG_RAMP_UP, 16'h0300);
    wr_reg(REG_IRQ_MASK, 16'h0010);
    start_stop(16'h0400, 4'(1 + $urandom % 4), 16'h0064);
    wait_done();
    `CHK("fault reaction", 1'b1, (t_tq - t_sup) <= 2)
    `CHK("brake with torque_off", t_tq, t_br)
    `CHK("irq fault", 1'b1, irq)
    release_stop(16'h0003);
    $display("test ramp fault done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
